//--- mem_order_consts.vh
// Constants shared by the memory ordering unit and its helper modules.
`ifndef MEM_ORDER_CONSTS_VH
`define MEM_ORDER_CONSTS_VH
`define ADDR_W 32
`define DATA_W 32
`define SB_DEPTH 8
`define SB_PTR_W 3
`define SB_CNT_W 4
`define SB_FULL 4'h8
`define TYPE_W 3
`define TYPE_WRITEBACK 3'h0
`define TYPE_WRITETHROUGH 3'h1
`define TYPE_WRITE_PROTECT 3'h2
`define TYPE_WRITE_COMBINING 3'h3
`define TYPE_WRITE_COMBINING_PLUS 3'h4
`define TYPE_UNCACHEABLE 3'h5
`define KIND_W 2
`define KIND_PLAIN 2'h0
`define KIND_PORT_IO 2'h1
`define KIND_ATOMIC 2'h2
`define KIND_SERIALIZE 2'h3
`define FENCE_W 2
`define FENCE_LOAD 2'h1
`define FENCE_STORE 2'h2
`define FENCE_FULL 2'h3
`define DEFER_LIMIT 4'hf
`endif

//--- store_buffer_lookup.v
// Address search of the store buffer for forwarding and uncacheable checks.
`include "mem_order_consts.vh"
module store_buffer_lookup (
   // Buffer contents.
   input wire [`SB_DEPTH-1:0] entryValid,
   input wire [`SB_DEPTH*`ADDR_W-1:0] entryAddrFlat,
   input wire [`SB_DEPTH*`DATA_W-1:0] entryDataFlat,
   input wire [`SB_DEPTH-1:0] entryUncached,
   input wire [`SB_PTR_W-1:0] head,
   // Address being looked up.
   input wire [`ADDR_W-1:0] lookAddr,
   // Results.
   output reg hit,
   output reg [`DATA_W-1:0] hitData,
   output wire anyUncached
);
   // Per-entry address match against valid entries only.
   wire [`SB_DEPTH-1:0] match;
   genvar g;
   generate
      for (g = 0; g < `SB_DEPTH; g = g + 1) begin : gMatch
         assign match[g] = entryValid[g] && (entryAddrFlat[g*`ADDR_W +: `ADDR_W] == lookAddr);
      end
   endgenerate

   // Any buffered uncacheable store blocks a later load.
   assign anyUncached = |(entryValid & entryUncached);

   // Walk from the oldest entry so the youngest match is the one kept.
   integer k;
   reg [`SB_PTR_W-1:0] idx;
   always @* begin
      hit = 1'b0;
      hitData = {`DATA_W{1'b0}};
      idx = head;
      for (k = 0; k < `SB_DEPTH; k = k + 1) begin
         idx = head + k[`SB_PTR_W-1:0];
         if (match[idx]) begin
            hit = 1'b1;
            hitData = entryDataFlat[idx*`DATA_W +: `DATA_W];
         end
      end
   end
endmodule // store_buffer_lookup

//--- mem_port_arbiter.v
// Chooses between a waiting load and a buffered write for the memory port.
`include "mem_order_consts.vh"
module mem_port_arbiter (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Requests.
   input wire loadReq,
   input wire drainReq,
   input wire drainUrgent,
   input wire portFree,
   // Grants.
   output wire grantLoad,
   output wire grantDrain
);
   // Counts loads that have jumped ahead of a waiting write.
   reg [3:0] defer_reg;
   reg [3:0] defer_next;
   wire starve;

   // Reads win so the pipeline stalls less, but a bounded number of times only,
   // so that a stream of loads cannot hold writes forever.
   assign starve = (defer_reg == `DEFER_LIMIT);
   assign grantDrain = portFree && drainReq && (!loadReq || drainUrgent || starve);
   assign grantLoad = portFree && loadReq && !grantDrain;

   // Next deferral count.
   always @* begin
      defer_next = defer_reg;
      if (grantDrain || !drainReq) begin
         defer_next = 4'h0;
      end else if (grantLoad) begin
         defer_next = defer_reg + 4'h1;
      end
   end

   // Deferral counter.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         defer_reg <= 4'h0;
      end else begin
         defer_reg <= defer_next;
      end
   end
endmodule // mem_port_arbiter

//--- memory_order_store_buffer.v
// Load/store ordering unit with an in-order write buffer.
`include "mem_order_consts.vh"
module memory_order_store_buffer (
   // Clock and reset.
   input wire clk_sys,
   input wire rst,
   // Requests from the pipeline, in program order.
   input wire reqValid,
   output wire reqReady,
   input wire reqStore,
   input wire [`TYPE_W-1:0] reqType,
   input wire reqStream,
   input wire [`KIND_W-1:0] reqKind,
   input wire [`ADDR_W-1:0] reqAddr,
   input wire [`DATA_W-1:0] reqData,
   // Barriers from the pipeline.
   input wire fenceValid,
   input wire [`FENCE_W-1:0] fenceKind,
   output wire fenceReady,
   // Interrupt or exception taken.
   input wire intrEvent,
   // Load answers and fetch control.
   output reg respValid,
   output reg [`DATA_W-1:0] respData,
   output reg fetchHold,
   output reg wcFlush,
   // Memory port.
   output reg memValid,
   input wire memReady,
   output reg memWrite,
   output reg [`ADDR_W-1:0] memAddr,
   output reg [`DATA_W-1:0] memData,
   output reg [`TYPE_W-1:0] memType,
   input wire memRdValid,
   input wire [`DATA_W-1:0] memRdData
);
   // Sequencer states.
   localparam ST_IDLE = 3'h0;
   localparam ST_LD_ISSUE = 3'h1;
   localparam ST_LD_WAIT = 3'h2;
   localparam ST_SP_DRAIN = 3'h3;
   localparam ST_SP_ISSUE = 3'h4;
   localparam ST_SP_WAIT = 3'h5;

   // True for the uncacheable memory type.
   function isUncached;
      input [`TYPE_W-1:0] t;
      begin
         isUncached = (t == `TYPE_UNCACHEABLE);
      end
   endfunction

   // Buffer storage and pointers.
   reg [`ADDR_W-1:0] bufAddr [0:`SB_DEPTH-1];
   reg [`DATA_W-1:0] bufData [0:`SB_DEPTH-1];
   reg [`TYPE_W-1:0] bufType [0:`SB_DEPTH-1];
   reg [`SB_PTR_W-1:0] head_reg;
   reg [`SB_PTR_W-1:0] tail_reg;
   reg [`SB_CNT_W-1:0] count_reg;
   // Sequencer state and the request it is working on.
   reg [2:0] state_reg;
   reg [`ADDR_W-1:0] pendAddr_reg;
   reg [`DATA_W-1:0] pendData_reg;
   reg [`TYPE_W-1:0] pendType_reg;
   reg pendStore_reg;
   reg pendSerial_reg;
   // Drain everything before any new request; set by a full barrier or an interrupt.
   reg drainAll_reg;
   reg intrHold_reg;

   // Flattened buffer view for the lookup module.
   wire [`SB_DEPTH-1:0] entryValid;
   wire [`SB_DEPTH*`ADDR_W-1:0] entryAddrFlat;
   wire [`SB_DEPTH*`DATA_W-1:0] entryDataFlat;
   wire [`SB_DEPTH-1:0] entryUncached;
   genvar g;
   generate
      for (g = 0; g < `SB_DEPTH; g = g + 1) begin : gView
         // Slot number cut to pointer width, so the age wraps like the pointers do.
         localparam integer SLOT = g;
         wire [`SB_PTR_W-1:0] age;
         assign age = SLOT[`SB_PTR_W-1:0] - head_reg;
         assign entryValid[g] = ({1'b0, age} < count_reg);
         assign entryAddrFlat[g*`ADDR_W +: `ADDR_W] = bufAddr[g];
         assign entryDataFlat[g*`DATA_W +: `DATA_W] = bufData[g];
         assign entryUncached[g] = isUncached(bufType[g]);
      end
   endgenerate

   // Lookup results for the pending load.
   wire fwdHit;
   wire [`DATA_W-1:0] fwdData;
   wire anyUncached;
   store_buffer_lookup uLookup (
      .entryValid(entryValid),
      .entryAddrFlat(entryAddrFlat),
      .entryDataFlat(entryDataFlat),
      .entryUncached(entryUncached),
      .head(head_reg),
      .lookAddr(pendAddr_reg),
      .hit(fwdHit),
      .hitData(fwdData),
      .anyUncached(anyUncached)
   );

   // Buffer status and the memory port's availability.
   wire bufEmpty = (count_reg == {`SB_CNT_W{1'b0}});
   wire bufFull = (count_reg == `SB_FULL);
   wire portFree = !memValid;
   wire isIdle = (state_reg == ST_IDLE);

   // A pending load may go to memory only when no ordering hazard stands.
   // Uncacheable loads wait for an empty buffer; others wait out any
   // buffered uncacheable store, and may otherwise pass buffered stores.
   wire ldUc = isUncached(pendType_reg);
   wire ldBlocked = ldUc ? !bufEmpty : anyUncached;
   wire ldForward = !ldUc && !anyUncached && fwdHit;
   wire loadReq = (state_reg == ST_LD_ISSUE) && !ldBlocked && !ldForward;

   // Writes are urgent when the buffer is full or a drain has been demanded.
   wire drainUrgent = bufFull || drainAll_reg || (state_reg == ST_SP_DRAIN);
   wire grantLoad;
   wire grantDrain;
   mem_port_arbiter uArb (
      .clk_sys(clk_sys),
      .rst(rst),
      .loadReq(loadReq),
      .drainReq(!bufEmpty),
      .drainUrgent(drainUrgent),
      .portFree(portFree),
      .grantLoad(grantLoad),
      .grantDrain(grantDrain)
   );

   // Request handshakes. Barriers take precedence over a request in the same cycle.
   // A store is taken only in idle, so every earlier load has already completed.
   wire isSpecial = (reqKind != `KIND_PLAIN);
   assign fenceReady = isIdle && !drainAll_reg;
   assign reqReady = isIdle && !drainAll_reg && !intrEvent && !fenceValid &&
      !(reqStore && !isSpecial && bufFull);
   wire reqTake = reqValid && reqReady;
   wire fenceTake = fenceValid && fenceReady;
   wire enqueue = reqTake && reqStore && !isSpecial;

   // Special issue happens once the buffer and port are both quiet.
   wire spGo = (state_reg == ST_SP_ISSUE) && portFree;

   // Buffer write side; entries are appended in program order.
   always @(posedge clk_sys) begin
      if (enqueue) begin
         bufAddr[tail_reg] <= reqAddr;
         bufData[tail_reg] <= reqData;
         bufType[tail_reg] <= reqStream ? `TYPE_WRITE_COMBINING : reqType;
      end
   end

   // Buffer pointers; only the oldest entry ever leaves.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         head_reg <= {`SB_PTR_W{1'b0}};
         tail_reg <= {`SB_PTR_W{1'b0}};
         count_reg <= {`SB_CNT_W{1'b0}};
      end else begin
         if (enqueue) begin
            tail_reg <= tail_reg + 3'h1;
         end
         if (grantDrain) begin
            head_reg <= head_reg + 3'h1;
         end
         if (enqueue && !grantDrain) begin
            count_reg <= count_reg + 4'h1;
         end else if (!enqueue && grantDrain) begin
            count_reg <= count_reg - 4'h1;
         end
      end
   end

   // Sequencer for loads and for port, atomic and serializing accesses.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         pendAddr_reg <= {`ADDR_W{1'b0}};
         pendData_reg <= {`DATA_W{1'b0}};
         pendType_reg <= `TYPE_WRITEBACK;
         pendStore_reg <= 1'b0;
         pendSerial_reg <= 1'b0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (reqTake && (isSpecial || !reqStore)) begin
                  pendAddr_reg <= reqAddr;
                  pendData_reg <= reqData;
                  pendType_reg <= reqType;
                  pendStore_reg <= reqStore;
                  pendSerial_reg <= (reqKind == `KIND_SERIALIZE);
                  // Special accesses first wait for all earlier work.
                  state_reg <= isSpecial ? ST_SP_DRAIN : ST_LD_ISSUE;
               end
            end
            ST_LD_ISSUE: begin
               if (ldForward) begin
                  state_reg <= ST_IDLE;
               end else if (grantLoad) begin
                  state_reg <= ST_LD_WAIT;
               end
            end
            ST_LD_WAIT: begin
               if (memRdValid) begin
                  state_reg <= ST_IDLE;
               end
            end
            ST_SP_DRAIN: begin
               // Nothing buffered and nothing in flight on the port.
               if (bufEmpty && portFree) begin
                  state_reg <= ST_SP_ISSUE;
               end
            end
            ST_SP_ISSUE: begin
               if (spGo) begin
                  state_reg <= ST_SP_WAIT;
               end
            end
            ST_SP_WAIT: begin
               // A write is done once memory takes it; a read once data returns.
               // No later request is taken before this point.
               if (pendStore_reg ? (memValid && memReady) : memRdValid) begin
                  state_reg <= ST_IDLE;
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
      end
   end

   // Memory port register. Special writes go straight here, never into the buffer.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         memValid <= 1'b0;
         memWrite <= 1'b0;
         memAddr <= {`ADDR_W{1'b0}};
         memData <= {`DATA_W{1'b0}};
         memType <= `TYPE_WRITEBACK;
      end else begin
         if (grantDrain) begin
            memValid <= 1'b1;
            memWrite <= 1'b1;
            memAddr <= bufAddr[head_reg];
            memData <= bufData[head_reg];
            memType <= bufType[head_reg];
         end else if (grantLoad || spGo) begin
            memValid <= 1'b1;
            memWrite <= spGo && pendStore_reg;
            memAddr <= pendAddr_reg;
            memData <= pendData_reg;
            memType <= pendType_reg;
         end else if (memReady) begin
            memValid <= 1'b0;
         end
      end
   end

   // Load answers, from the buffer or from memory.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         respValid <= 1'b0;
         respData <= {`DATA_W{1'b0}};
      end else begin
         respValid <= 1'b0;
         if ((state_reg == ST_LD_ISSUE) && ldForward) begin
            respValid <= 1'b1;
            respData <= fwdData;
         end else if (((state_reg == ST_LD_WAIT) ||
            ((state_reg == ST_SP_WAIT) && !pendStore_reg)) && memRdValid) begin
            respValid <= 1'b1;
            respData <= memRdData;
         end
      end
   end

   // Drain demands, fetch hold and the combining flush strobe.
   // A new demand in the cycle the drain finishes keeps the flag set.
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         drainAll_reg <= 1'b0;
         intrHold_reg <= 1'b0;
         fetchHold <= 1'b0;
         wcFlush <= 1'b0;
      end else begin
         if (intrEvent || (fenceTake && (fenceKind == `FENCE_FULL))) begin
            drainAll_reg <= 1'b1;
         end else if (bufEmpty && portFree && isIdle) begin
            drainAll_reg <= 1'b0;
         end
         if (intrEvent) begin
            intrHold_reg <= 1'b1;
         end else if (bufEmpty && portFree) begin
            intrHold_reg <= 1'b0;
         end
         // Fetch waits on an interrupt drain or until a serializing access retires.
         fetchHold <= intrEvent || (intrHold_reg && !(bufEmpty && portFree)) ||
            (reqTake && (reqKind == `KIND_SERIALIZE)) ||
            (pendSerial_reg && !isIdle);
         // Store and full barriers, special accesses and interrupts flush combining.
         wcFlush <= intrEvent || (reqTake && isSpecial) ||
            (fenceTake && (fenceKind != `FENCE_LOAD));
      end
   end
endmodule // memory_order_store_buffer

//--- mem_order_properties.sv
// Port-level assertions for the memory ordering unit, bound to its top module.
`include "mem_order_consts.vh"
module mem_order_checker (
   // Clock and reset.
   input wire logic clk_sys,
   input wire logic rst,
   // Pipeline side.
   input wire logic reqValid,
   input wire logic reqReady,
   input wire logic reqStore,
   input wire logic [`KIND_W-1:0] reqKind,
   input wire logic fenceValid,
   input wire logic fenceReady,
   input wire logic [`FENCE_W-1:0] fenceKind,
   input wire logic intrEvent,
   // Answers and memory port.
   input wire logic respValid,
   input wire logic fetchHold,
   input wire logic wcFlush,
   input wire logic memValid,
   input wire logic memReady,
   input wire logic [`ADDR_W-1:0] memAddr,
   input wire logic [`DATA_W-1:0] memData,
   input wire logic [`TYPE_W-1:0] memType,
   input wire logic memRdValid
);
   timeunit 1ns;
   timeprecision 1ns;
   // A load being taken; kept as a net that the loadOpen register below samples.
   wire loadTake = reqValid && reqReady && !reqStore;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   // A load stays open from its take until its one answer; a load held up by
   // an uncacheable store may later be forwarded, so no fixed delay is assumed.
   logic loadOpen;
   always @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         loadOpen <= 1'b0;
      end else if (loadTake) begin
         loadOpen <= 1'b1;
      end else if (respValid) begin
         loadOpen <= 1'b0;
      end
   end
   // Request and barrier acceptance, the first step of every ordered action.
   sequence s_take; reqValid && reqReady; endsequence
   sequence s_fenceTake; fenceValid && fenceReady; endsequence
   // The memory side must see a request that does not move until it is taken.
   property p_memHold; memValid && !memReady |=> memValid && $stable(memAddr) && $stable(memData) &&
      $stable(memType); endproperty
   // An answer comes only for an open load, and only once for it.
   property p_respCause; respValid |-> loadOpen; endproperty
   property p_flushOnFence; s_fenceTake ##0 (fenceKind != `FENCE_LOAD) |=> wcFlush; endproperty
   property p_fullBlocks; s_fenceTake ##0 (fenceKind == `FENCE_FULL) |=> !reqReady; endproperty
   property p_intrHold; intrEvent |=> fetchHold && wcFlush; endproperty
   property p_intrRefuse; intrEvent |-> !reqReady; endproperty
   property p_fenceFirst; fenceValid |-> !reqReady; endproperty
   property p_serialHold; s_take ##0 (reqKind == `KIND_SERIALIZE) |=> fetchHold; endproperty
   // A load holds off everything behind it, so no store can overtake it.
   property p_loadBlocks; s_take ##0 !reqStore |=> !reqReady; endproperty
   a_memHold: assert property (p_memHold) else $error("memory request changed before taken");
   a_respCause: assert property (p_respCause) else $error("load answer without cause");
   a_flushOnFence: assert property (p_flushOnFence) else $error("no combining flush");
   a_fullBlocks: assert property (p_fullBlocks) else $error("full barrier let a request in");
   a_intrHold: assert property (p_intrHold) else $error("interrupt did not hold fetch");
   a_intrRefuse: assert property (p_intrRefuse) else $error("request taken at interrupt");
   a_fenceFirst: assert property (p_fenceFirst) else $error("request beat a barrier");
   a_serialHold: assert property (p_serialHold) else $error("serializing did not hold fetch");
   a_loadBlocks: assert property (p_loadBlocks) else $error("request passed open load");
endmodule // mem_order_checker
bind memory_order_store_buffer mem_order_checker i_mem_order_checker (.clk_sys, .rst, .reqValid,
   .reqReady, .reqStore, .reqKind, .fenceValid, .fenceReady, .fenceKind, .intrEvent, .respValid,
   .fetchHold, .wcFlush, .memValid, .memReady, .memAddr, .memData, .memType, .memRdValid);

//--- mem_partner.sv
// Behavioural memory that answers the ordering unit's memory port.
`include "mem_order_consts.vh"
module mem_partner (
   // Clock, reset and pace.
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic slow,
   // Memory port.
   input wire logic memValid,
   output logic memReady,
   input wire logic memWrite,
   input wire logic [`ADDR_W-1:0] memAddr,
   input wire logic [`DATA_W-1:0] memData,
   output logic memRdValid,
   output logic [`DATA_W-1:0] memRdData
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [`DATA_W-1:0] mem [logic [`ADDR_W-1:0]]; // Stored words.
   logic [`ADDR_W-1:0] wrAddr [$]; // Write addresses in arrival order.
   int rdPos; // Writes already landed when the last read arrived.
   logic take, w;
   logic [`ADDR_W-1:0] a;
   logic [`DATA_W-1:0] d;
   // Handshake is judged at the falling edge, where the registered request is settled.
   // Read data toggles when not valid, so a stale word is never mistaken for an answer.
   initial begin
      memReady = 1'b0;
      memRdValid = 1'b0;
      memRdData = 32'h0;
      rdPos = 0;
      forever begin
         @(negedge clk_sys);
         take = memValid && memReady && !rst;
         w = memWrite;
         a = memAddr;
         d = memData;
         @(posedge clk_sys);
         #1;
         memRdValid = 1'b0;
         memRdData = ~memRdData;
         if (take && w) begin
            mem[a] = d;
            wrAddr.push_back(a);
         end else if (take) begin
            rdPos = wrAddr.size();
            memRdValid = 1'b1;
            memRdData = mem.exists(a) ? mem[a] : a ^ 32'h0f0f0f0f;
         end
         // A slow memory accepts only now and then, stalling the drain.
         memReady = !slow || ($urandom_range(3) == 0);
      end
   end
endmodule // mem_partner

//--- tb.sv
// Self-checking bench for the memory ordering unit with a reference model.
`include "mem_order_consts.vh"
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk_sys, rst, reqValid, reqStore, reqStream, fenceValid, intrEvent, slow;
   logic [`TYPE_W-1:0] reqType;
   logic [`KIND_W-1:0] reqKind;
   logic [`ADDR_W-1:0] reqAddr;
   logic [`DATA_W-1:0] reqData;
   logic [`FENCE_W-1:0] fenceKind;
   wire reqReady, fenceReady, respValid, fetchHold, wcFlush, memValid, memReady, memWrite, memRdValid;
   wire [`ADDR_W-1:0] memAddr;
   wire [`DATA_W-1:0] respData, memData, memRdData;
   int mismatches, samples_checked, i, k;
   logic [`DATA_W-1:0] model [logic [`ADDR_W-1:0]]; // Value each word should read.
   logic [`ADDR_W-1:0] expWr [$]; // Writes in program order.
   memory_order_store_buffer i_memory_order_store_buffer (.clk_sys(clk_sys), .rst(rst),
      .reqValid(reqValid), .reqReady(reqReady), .reqStore(reqStore), .reqType(reqType),
      .reqStream(reqStream), .reqKind(reqKind), .reqAddr(reqAddr), .reqData(reqData),
      .fenceValid(fenceValid), .fenceKind(fenceKind), .fenceReady(fenceReady),
      .intrEvent(intrEvent), .respValid(respValid), .respData(respData), .fetchHold(fetchHold),
      .wcFlush(wcFlush), .memValid(memValid), .memReady(memReady), .memWrite(memWrite),
      .memAddr(memAddr), .memData(memData), .memType(), .memRdValid(memRdValid),
      .memRdData(memRdData));
   mem_partner i_mem_partner (.clk_sys(clk_sys), .rst(rst), .slow(slow), .memValid(memValid),
      .memReady(memReady), .memWrite(memWrite), .memAddr(memAddr), .memData(memData),
      .memRdValid(memRdValid), .memRdData(memRdData));
   // Clock of 40 ns period.
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   // Compares one result word.
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // Prints the counts and the verdict, then stops.
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // Presents one request until taken; stores stay presented so they can run back to back.
   task automatic req(input logic st, input logic [2:0] ty, input logic sm, input logic [1:0] kd,
                      input logic [31:0] a, input logic [31:0] d);
      logic ok;
      reqValid = 1'b1;
      reqStore = st;
      reqType = ty;
      reqStream = sm;
      reqKind = kd;
      reqAddr = a;
      reqData = d;
      k = 0;
      do begin
         @(negedge clk_sys);
         ok = reqReady;
         @(posedge clk_sys);
         #1;
         k++;
      end while (!ok && k < 3000);
      check({31'h0, ok}, 32'h1);
      if (st) begin
         model[a] = d;
         expWr.push_back(a);
      end else begin
         reqValid = 1'b0;
         k = 0;
         do begin
            @(negedge clk_sys);
            k++;
         end while (respValid !== 1'b1 && k < 3000);
         check(respData, model.exists(a) ? model[a] : a ^ 32'h0f0f0f0f);
         @(posedge clk_sys);
         #1;
      end
   endtask
   // Withdraws a presented store.
   task automatic idle;
      reqValid = 1'b0;
      @(posedge clk_sys);
      #1;
   endtask
   // Presents one barrier until taken.
   task automatic fence(input logic [1:0] fk);
      logic ok;
      fenceValid = 1'b1;
      fenceKind = fk;
      k = 0;
      do begin
         @(negedge clk_sys);
         ok = fenceReady;
         @(posedge clk_sys);
         #1;
         k++;
      end while (!ok && k < 3000);
      fenceValid = 1'b0;
      check({31'h0, ok}, 32'h1);
      @(posedge clk_sys);
      #1;
   endtask
   // The last read must have seen every earlier write in memory.
   task automatic seen_all;
      check(32'(i_mem_partner.rdPos), 32'(expWr.size()));
   endtask
   // A hang ends the run through the normal closing path.
   initial begin
      repeat (60000) @(posedge clk_sys);
      mismatches++;
      finish_test;
   end
   initial begin
      {reqValid, reqStore, reqStream, fenceValid, intrEvent, slow} = 6'h00;
      reqType = 3'h0;
      reqKind = 2'h0;
      reqAddr = 32'h0;
      reqData = 32'h0;
      fenceKind = 2'h0;
      rst = 1'b1;
      void'($urandom(17002));
      repeat (16) @(posedge clk_sys);
      #1;
      rst = 1'b0;
      // Ten stores run back to back but drain every other cycle, so at most five wait; then loads forward or miss.
      for (i = 0; i < 10; i++) req(1, i % 3, 0, 0, 32'h100 + i, $urandom);
      idle;
      for (i = 9; i >= 0; i -= 3) req(0, i % 4, 0, 0, 32'h100 + i, 0);
      $display("test buffer fill done");
      req(1, `TYPE_WRITEBACK, 0, 0, 32'h200, $urandom);
      idle;
      fence(`FENCE_FULL);
      req(0, `TYPE_WRITEBACK, 0, 0, 32'h300, 0);
      seen_all;
      fence(`FENCE_LOAD);
      req(1, `TYPE_WRITE_COMBINING, 1, 0, 32'h310, $urandom);
      idle;
      fence(`FENCE_STORE);
      fence(`FENCE_FULL);
      $display("test barriers done");
      req(1, `TYPE_UNCACHEABLE, 0, 0, 32'h400, $urandom);
      idle;
      req(0, `TYPE_WRITE_PROTECT, 0, 0, 32'h500, 0);
      seen_all;
      req(1, `TYPE_WRITETHROUGH, 0, 0, 32'h600, $urandom);
      idle;
      req(0, `TYPE_UNCACHEABLE, 0, 0, 32'h700, 0);
      seen_all;
      $display("test uncacheable done");
      for (i = 1; i < 4; i++) begin
         req(1, `TYPE_WRITE_COMBINING_PLUS, 0, 0, 32'h800 + i, $urandom);
         req(1, `TYPE_WRITEBACK, 0, i, 32'h880 + i, $urandom);
         idle;
         req(0, `TYPE_WRITEBACK, 0, i, 32'h900 + i, 0);
         seen_all;
      end
      $display("test special kinds done");
      for (i = 0; i < 4; i++) req(1, `TYPE_WRITEBACK, 0, 0, 32'ha00 + i, $urandom);
      idle;
      intrEvent = 1'b1;
      @(posedge clk_sys);
      #1;
      intrEvent = 1'b0;
      k = 0;
      do begin
         @(posedge clk_sys);
         #1;
         k++;
      end while (fetchHold !== 1'b0 && k < 3000);
      check(32'(i_mem_partner.wrAddr.size()), 32'(expWr.size()));
      $display("test interrupt done");
      slow = 1'b1;
      for (i = 0; i < 60; i++) begin
         if ($urandom_range(2) != 0)
            req(1, $urandom_range(5), $urandom_range(1), 0, 32'hb00 + $urandom_range(15), $urandom);
         else
            req(0, $urandom_range(5), 0, 0, 32'hb00 + $urandom_range(15), 0);
      end
      idle;
      fence(`FENCE_FULL);
      req(0, `TYPE_WRITEBACK, 0, 0, 32'hc00, 0);
      seen_all;
      for (i = 0; i < expWr.size(); i++) check(i_mem_partner.wrAddr[i], expWr[i]);
      $display("test random traffic done");
      finish_test;
   end
endmodule // tb
